// ---- hw/exc_unit.sv ----
`default_nettype none
module exc_unit
	import exc_pkg::*;
(
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic instr_valid,
	input wire logic instr_is_float,
	input wire logic instr_illegal,
	input wire logic instr_privileged,
	input wire logic instr_spr_move,
	input wire logic instr_spr_invalid,
	input wire logic [9:0] special_register_number,
	input wire logic instr_trap_hit,
	input wire logic instr_is_sc,
	input wire logic fp_enabled_exc,
	input wire logic fsc_write,
	input wire logic [exc_pkg::FSC_FIELDS-1:0] fsc_exc_bits,
	input wire logic [exc_pkg::FSC_FIELDS-1:0] fsc_en_bits,
	input wire logic [exc_pkg::MSW_WIDTH-1:0] machine_state_word,
	input wire logic [31:0] down_counter_reg,
	input wire logic [3:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	output logic [31:0] reg_rdata,
	output logic exc_take,
	output logic [19:0] exc_kind_offset,
	output logic [31:0] exc_fetch_addr,
	output logic [exc_pkg::SSW_WIDTH-1:0] saved_status_word,
	output logic float_enabled_summary,
	output logic irq
);
	import exc_pkg::*;

	typedef enum {ST_RUN, ST_HOLD} phase_e;

	// all state of the unit but the float summary flag (held in u_fsum) in one packed struct
	typedef struct packed {
		phase_e phase;
		logic msb_prev;
		logic dec_pending;
		logic take;
		logic [19:0] offset;
		logic [31:0] fetch;
		logic [SSW_WIDTH-1:0] cause;
		logic [EVT_WIDTH-1:0] status;
		logic [EVT_WIDTH-1:0] mask;
		logic [31:0] vbase;
		logic no_fpu;
		logic [31:0] rdata;
		logic irq;
	} unit_s;

	// registered state and its next value
	unit_s st;
	unit_s next_st;
	// condition terms and requests, filled combinationally
	logic fsum;
	logic mode_or;
	logic cond_float;
	logic cond_illegal;
	logic cond_priv;
	logic cond_trap;
	logic req_program;
	logic req_unavail;
	logic req_sc;
	logic take_dec;
	logic [EVT_WIDTH-1:0] evt;
	logic [SSW_WIDTH-1:0] cause_vec;

	// ********************************************************
	// float summary flag
	// ********************************************************
	exc_fsum u_fsum (
		.clk_sys(clk_sys),
		.reset(reset),
		.fp_enabled_exc(fp_enabled_exc),
		.fsc_write(fsc_write),
		.fsc_exc_bits(fsc_exc_bits),
		.fsc_en_bits(fsc_en_bits),
		.float_enabled_summary(fsum)
	);

	// ********************************************************
	// condition detection
	// ********************************************************
	// program and other exception conditions from the current instruction, and the down counter take term
	always_comb begin
		mode_or = machine_state_word[MSW_FE0_POS]
			| machine_state_word[MSW_FE1_POS];
		cond_float = instr_valid && instr_is_float && !st.no_fpu
			&& mode_or && fsum;
		cond_illegal = instr_valid && instr_illegal;
		cond_priv = instr_valid && machine_state_word[MSW_PR_POS]
			&& (instr_privileged || (instr_spr_move && instr_spr_invalid
			&& special_register_number[9]));
		cond_trap = instr_valid && instr_trap_hit;
		cause_vec = '0;
		cause_vec[SSW_FLOAT_POS] = cond_float;
		cause_vec[SSW_ILLEGAL_POS] = cond_illegal;
		cause_vec[SSW_PRIV_POS] = cond_priv;
		cause_vec[SSW_TRAP_POS] = cond_trap;
		req_program = |cause_vec;
		req_unavail = instr_valid && instr_is_float
			&& (st.no_fpu || !machine_state_word[MSW_FP_POS]);
		req_sc = instr_valid && instr_is_sc;
		take_dec = st.dec_pending && machine_state_word[MSW_EE_POS];
	end

	// ********************************************************
	// selection, registers and state
	// ********************************************************
	// fixed priority: program, fp unavailable, system call, down counter
	always_comb begin
		next_st = st;
		next_st.take = 1'b0;
		next_st.rdata = '0;
		evt = '0;
		case (st.phase)
			ST_RUN: begin
				if (req_program) begin
					next_st.take = 1'b1;
					next_st.offset = VEC_PROGRAM;
					next_st.cause = cause_vec;
					evt[EVT_PROGRAM] = 1'b1;
				end else if (req_unavail) begin
					next_st.take = 1'b1;
					next_st.offset = VEC_FLOAT_UNAVAIL;
					evt[EVT_FLOAT_UNAVAIL] = 1'b1;
				end else if (req_sc) begin
					next_st.take = 1'b1;
					next_st.offset = VEC_SYS_CALL;
					evt[EVT_SYS_CALL] = 1'b1;
				end else if (take_dec) begin
					next_st.take = 1'b1;
					next_st.offset = VEC_DOWN_COUNTER;
					next_st.dec_pending = 1'b0;
					evt[EVT_DOWN_COUNTER] = 1'b1;
				end
				if (next_st.take) begin
					next_st.fetch = st.vbase + {12'h000, next_st.offset};
					next_st.phase = ST_HOLD;
				end
			end
			// an instruction meeting the gap cycle is dropped, not held
			ST_HOLD: begin
				next_st.phase = ST_RUN; // one exception then a gap cycle
			end
			default: begin
				next_st.phase = ST_RUN;
			end
		endcase
		// down counter edge after the selection, so a new edge wins
		// over the clear of a pending request taken in the same cycle
		next_st.msb_prev = down_counter_reg[DOWN_COUNTER_MSB];
		if (down_counter_reg[DOWN_COUNTER_MSB] && !st.msb_prev) begin
			next_st.dec_pending = 1'b1;
		end
		// register writes; status is write-one-to-clear, set wins
		if (reg_write) begin
			case (reg_addr)
				REG_STATUS: next_st.status = st.status & ~reg_wdata[EVT_WIDTH-1:0];
				REG_MASK: next_st.mask = reg_wdata[EVT_WIDTH-1:0];
				REG_VBASE: next_st.vbase = reg_wdata;
				REG_CONTROL: next_st.no_fpu = reg_wdata[CTRL_NO_FPU_POS];
				default: ;
			endcase
		end
		next_st.status = next_st.status | evt;
		if (reg_read) begin
			case (reg_addr)
				REG_STATUS: next_st.rdata = {28'h0000000, st.status};
				REG_MASK: next_st.rdata = {28'h0000000, st.mask};
				REG_CAUSE: next_st.rdata = {28'h0000000, st.cause};
				REG_VBASE: next_st.rdata = st.vbase;
				REG_CONTROL: next_st.rdata = {31'h00000000, st.no_fpu};
				default: next_st.rdata = '0;
			endcase
		end
		next_st.irq = |(next_st.status & next_st.mask);
	end

	// state register
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			st <= '{phase: ST_RUN, msb_prev: 1'b0, dec_pending: 1'b0,
				take: 1'b0, offset: VEC_BASE_RESET, fetch: 32'h00000000,
				cause: '0, status: '0, mask: MASK_RESET[EVT_WIDTH-1:0],
				vbase: 32'h00000000, no_fpu: CONTROL_RESET[CTRL_NO_FPU_POS],
				rdata: 32'h00000000, irq: 1'b0};
		end else begin
			st <= next_st;
		end
	end

	// outputs straight from flip-flops
	assign reg_rdata = st.rdata;
	assign exc_take = st.take;
	assign exc_kind_offset = st.offset;
	assign exc_fetch_addr = st.fetch;
	assign saved_status_word = st.cause;
	assign float_enabled_summary = fsum;
	assign irq = st.irq;

	// ********************************************************
	// assertions
	// ********************************************************
	// named steps of the multi-cycle checks
	sequence s_program_req;
		st.phase == ST_RUN && req_program;
	endsequence
	sequence s_program_taken;
		exc_take && exc_kind_offset == 20'h00700;
	endsequence
	sequence s_msb_rise;
		down_counter_reg[DOWN_COUNTER_MSB] && !st.msb_prev;
	endsequence
	sequence s_dec_only;
		st.phase == ST_RUN && st.dec_pending
		&& machine_state_word[MSW_EE_POS]
		&& !req_program && !req_unavail && !req_sc;
	endsequence
	sequence s_dec_taken;
		exc_take && exc_kind_offset == 20'h00900;
	endsequence

	a_program_vector: assert property (@(posedge clk_sys) disable iff (reset)
		s_program_req |=> s_program_taken)
		else $error("program exception not taken at 0x700");
	a_cause_record: assert property (@(posedge clk_sys) disable iff (reset)
		s_program_req |=> saved_status_word == $past(cause_vec))
		else $error("cause bits not recorded");

	// exception conditions, vectors and the one-exception gap, seen from the pins and the cause bits
	a_float_cond: assert property (@(posedge clk_sys) disable iff (reset)
		st.phase == ST_RUN && instr_valid && instr_is_float && !st.no_fpu
		&& (machine_state_word[MSW_FE0_POS]
		|| machine_state_word[MSW_FE1_POS]) && float_enabled_summary
		|=> exc_take && exc_kind_offset == 20'h00700
		&& saved_status_word[SSW_FLOAT_POS])
		else $error("fp enabled condition not taken");
	a_nofpu_float: assert property (@(posedge clk_sys) disable iff (reset)
		exc_take && exc_kind_offset == 20'h00700 && $past(st.no_fpu)
		|-> !saved_status_word[SSW_FLOAT_POS])
		else $error("fp enabled condition on no-fpu variant");
	a_illegal_cause: assert property (@(posedge clk_sys) disable iff (reset)
		st.phase == ST_RUN && instr_valid && instr_illegal
		|=> exc_take && saved_status_word[SSW_ILLEGAL_POS])
		else $error("illegal instruction not reported");
	a_priv_problem: assert property (@(posedge clk_sys) disable iff (reset)
		st.phase == ST_RUN && instr_valid && instr_privileged
		&& machine_state_word[MSW_PR_POS]
		|=> saved_status_word[SSW_PRIV_POS])
		else $error("privileged exception missing");
	a_spr_priv: assert property (@(posedge clk_sys) disable iff (reset)
		st.phase == ST_RUN && instr_valid && instr_spr_move
		&& instr_spr_invalid && special_register_number[9]
		&& machine_state_word[MSW_PR_POS]
		|=> saved_status_word[SSW_PRIV_POS])
		else $error("invalid special register not privileged");
	a_trap_cause: assert property (@(posedge clk_sys) disable iff (reset)
		st.phase == ST_RUN && instr_valid && instr_trap_hit
		|=> saved_status_word[SSW_TRAP_POS])
		else $error("trap not reported");
	a_unavail_vec: assert property (@(posedge clk_sys) disable iff (reset)
		st.phase == ST_RUN && !req_program && req_unavail
		|=> exc_take && exc_kind_offset == 20'h00800)
		else $error("fp unavailable not taken at 0x800");
	a_sc_vec: assert property (@(posedge clk_sys) disable iff (reset)
		st.phase == ST_RUN && !req_program && !req_unavail && req_sc
		|=> exc_take && exc_kind_offset == 20'h00C00)
		else $error("system call not taken at 0xC00");
	a_dec_enable: assert property (@(posedge clk_sys) disable iff (reset)
		exc_take && exc_kind_offset == 20'h00900
		|-> $past(machine_state_word[MSW_EE_POS]))
		else $error("down counter taken with interrupt enable clear");
	a_one_gap: assert property (@(posedge clk_sys) disable iff (reset)
		exc_take |=> !exc_take)
		else $error("two exceptions back to back");

	// down counter: latched on the rising msb, held until taken
	a_dec_latch: assert property (@(posedge clk_sys) disable iff (reset)
		s_msb_rise |=> st.dec_pending)
		else $error("down counter edge not latched");
	a_dec_hold: assert property (@(posedge clk_sys) disable iff (reset)
		st.dec_pending && !machine_state_word[MSW_EE_POS]
		|=> st.dec_pending)
		else $error("down counter request lost while disabled");
	a_dec_vector: assert property (@(posedge clk_sys) disable iff (reset)
		s_dec_only |=> s_dec_taken)
		else $error("down counter not taken at 0x900");
	a_dec_priority: assert property (@(posedge clk_sys) disable iff (reset)
		st.phase == ST_RUN && st.dec_pending
		&& (req_program || req_unavail || req_sc)
		|=> st.dec_pending)
		else $error("down counter request dropped by a higher one");

	// gap cycle and fetch address
	a_hold_refuse: assert property (@(posedge clk_sys) disable iff (reset)
		st.phase == ST_HOLD |=> !exc_take)
		else $error("exception taken out of the gap cycle");
	a_fetch_addr: assert property (@(posedge clk_sys) disable iff (reset)
		exc_take |-> exc_fetch_addr
		== $past(st.vbase) + {12'h000, exc_kind_offset})
		else $error("fetch address is not base plus offset");

	// no exception where the rules give none
	a_priv_user: assert property (@(posedge clk_sys) disable iff (reset)
		st.phase == ST_RUN && instr_valid && !machine_state_word[MSW_PR_POS]
		|=> !(exc_take && exc_kind_offset == 20'h00700
		&& saved_status_word[SSW_PRIV_POS]))
		else $error("privileged exception outside problem state");
	a_fpu_ready: assert property (@(posedge clk_sys) disable iff (reset)
		st.phase == ST_RUN && instr_valid && instr_is_float
		&& machine_state_word[MSW_FP_POS] && !st.no_fpu
		|=> !(exc_take && exc_kind_offset == 20'h00800))
		else $error("fp unavailable with fp available set");

	// cause and status bookkeeping
	a_cause_hold: assert property (@(posedge clk_sys) disable iff (reset)
		exc_take && exc_kind_offset != 20'h00700
		|-> $stable(saved_status_word))
		else $error("cause bits changed by a non-program exception");
	a_program_status: assert property (@(posedge clk_sys) disable iff (reset)
		exc_take && exc_kind_offset == 20'h00700
		|-> st.status[EVT_PROGRAM])
		else $error("program event not recorded in status");
	a_sc_status: assert property (@(posedge clk_sys) disable iff (reset)
		exc_take && exc_kind_offset == 20'h00C00
		|-> st.status[EVT_SYS_CALL])
		else $error("system call event not recorded in status");
endmodule
`default_nettype wire

// ---- hw/exc_pkg.sv ----
`default_nettype none
package exc_pkg;
	// vector offsets
	localparam logic [19:0] VEC_PROGRAM = 20'h00700;
	localparam logic [19:0] VEC_FLOAT_UNAVAIL = 20'h00800;
	localparam logic [19:0] VEC_DOWN_COUNTER = 20'h00900;
	localparam logic [19:0] VEC_SYS_CALL = 20'h00C00;
	localparam logic [19:0] VEC_BASE_RESET = 20'h00000;
	// machine state word field positions (bit 0 is lsb here)
	localparam int MSW_FE0_POS = 0;
	localparam int MSW_FE1_POS = 1;
	localparam int MSW_FP_POS = 2;
	localparam int MSW_PR_POS = 3;
	localparam int MSW_EE_POS = 4;
	localparam int MSW_WIDTH = 5;
	// saved status word cause bit positions
	localparam int SSW_FLOAT_POS = 0;
	localparam int SSW_ILLEGAL_POS = 1;
	localparam int SSW_PRIV_POS = 2;
	localparam int SSW_TRAP_POS = 3;
	localparam int SSW_WIDTH = 4;
	// float status control: exception and enable fields
	localparam int FSC_FIELDS = 5;
	localparam int DOWN_COUNTER_MSB = 31;
	// interrupt register fields, one per exception kind
	localparam int EVT_PROGRAM = 0;
	localparam int EVT_FLOAT_UNAVAIL = 1;
	localparam int EVT_DOWN_COUNTER = 2;
	localparam int EVT_SYS_CALL = 3;
	localparam int EVT_WIDTH = 4;
	// software register indices
	localparam logic [3:0] REG_STATUS = 4'h0;
	localparam logic [3:0] REG_MASK = 4'h1;
	localparam logic [3:0] REG_CAUSE = 4'h2;
	localparam logic [3:0] REG_VBASE = 4'h3;
	localparam logic [3:0] REG_CONTROL = 4'h4;
	localparam logic [31:0] MASK_RESET = 32'h00000000;
	localparam logic [31:0] CONTROL_RESET = 32'h00000000;
	localparam int CTRL_NO_FPU_POS = 0;
endpackage
`default_nettype wire

// ---- hw/exc_fsum.sv ----
// float enabled summary flag tracker
`default_nettype none
module exc_fsum
	import exc_pkg::*;
(
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic fp_enabled_exc,
	input wire logic fsc_write,
	input wire logic [exc_pkg::FSC_FIELDS-1:0] fsc_exc_bits,
	input wire logic [exc_pkg::FSC_FIELDS-1:0] fsc_en_bits,
	output logic float_enabled_summary
);
	import exc_pkg::*;
	typedef struct packed {
		logic summary;
	} fsum_s;
	fsum_s st;
	fsum_s next_st;

	// set on enabled fp exception or matched move-to-status pair
	always_comb begin
		next_st = st;
		if (fsc_write) begin
			next_st.summary = |(fsc_exc_bits & fsc_en_bits);
		end
		if (fp_enabled_exc) begin
			next_st.summary = 1'b1;
		end
	end

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign float_enabled_summary = st.summary;

	a_fsum_set: assert property (@(posedge clk_sys) disable iff (reset)
		fp_enabled_exc |=> float_enabled_summary)
		else $error("summary flag not set after enabled fp exception");
	a_fsum_mtfs: assert property (@(posedge clk_sys) disable iff (reset)
		fsc_write && |(fsc_exc_bits & fsc_en_bits)
		|=> float_enabled_summary)
		else $error("summary flag not set by status write");
endmodule
`default_nettype wire

// ---- verif/tb_program_fpu_dec_syscall_exceptions.sv ----
`default_nettype none
module tb_program_fpu_dec_syscall_exceptions;
	timeunit 1ns;
	timeprecision 1ps;
	import exc_pkg::*;
	logic clk_sys = 0, reset = 1, instr_valid = 0, instr_is_float = 0;
	logic instr_illegal = 0, instr_privileged = 0, instr_spr_move = 0;
	logic instr_spr_invalid = 0, instr_trap_hit = 0, instr_is_sc = 0;
	logic fp_enabled_exc = 0, fsc_write = 0, reg_write = 0, reg_read = 0;
	logic [9:0] special_register_number = '0;
	logic [4:0] fsc_exc_bits = '0, fsc_en_bits = '0;
	logic [MSW_WIDTH-1:0] machine_state_word = '0;
	logic [31:0] down_counter_reg = '0, reg_wdata = '0, reg_rdata;
	logic [31:0] exc_fetch_addr, vb = '0, seed = 32'hAC60;
	logic [3:0] reg_addr = '0, saved_status_word, cause = '0;
	logic [19:0] exc_kind_offset;
	logic exc_take, float_enabled_summary, irq, saw_read = 0;
	logic [19:0] off_q[$];
	logic [3:0] cause_q[$];
	logic [31:0] rd_q[$];
	int err_total = 0, total_checks = 0;

	exc_unit DUT (.clk_sys, .reset, .instr_valid, .instr_is_float,
		.instr_illegal, .instr_privileged, .instr_spr_move,
		.instr_spr_invalid, .special_register_number, .instr_trap_hit,
		.instr_is_sc, .fp_enabled_exc, .fsc_write, .fsc_exc_bits,
		.fsc_en_bits, .machine_state_word, .down_counter_reg, .reg_addr,
		.reg_wdata, .reg_write, .reg_read, .reg_rdata, .exc_take,
		.exc_kind_offset, .exc_fetch_addr, .saved_status_word,
		.float_enabled_summary, .irq);

	// ****************************************
	// clock, helpers and tasks
	// ****************************************
	always #5 clk_sys = ~clk_sys;

	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction

	task automatic chk(input logic ok, input string m);
		total_checks++;
		if (ok !== 1'b1) begin
			err_total++;
			$display("CHECK FAILED at %0t: %s", $time, m);
		end
	endtask

	task automatic tally_and_finish();
		if (err_total == 0 && total_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// note an expected take; program takes also update the cause
	task automatic note(input logic [19:0] off, input logic [3:0] c);
		if (off == VEC_PROGRAM) cause = c;
		off_q.push_back(off);
		cause_q.push_back(cause);
	endtask

	// one instruction: {sc, trap, spr_inv, spr_move, priv, illegal, float}
	task automatic issue(input logic [6:0] f);
		@(posedge clk_sys);
		instr_valid <= 1'b1;
		{instr_is_sc, instr_trap_hit, instr_spr_invalid, instr_spr_move,
			instr_privileged, instr_illegal, instr_is_float} <= f;
		@(posedge clk_sys);
		instr_valid <= 1'b0;
		{instr_is_sc, instr_trap_hit, instr_spr_invalid, instr_spr_move,
			instr_privileged, instr_illegal, instr_is_float} <= '0;
		repeat (3) @(posedge clk_sys);
	endtask

	task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		reg_write <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk_sys);
		reg_write <= 1'b0;
	endtask

	task automatic reg_rd(input logic [3:0] a, input logic [31:0] e);
		rd_q.push_back(e);
		@(posedge clk_sys);
		reg_read <= 1'b1;
		reg_addr <= a;
		@(posedge clk_sys);
		reg_read <= 1'b0;
		@(posedge clk_sys);
	endtask

	// float status write or enabled-exception pulse, then summary check
	task automatic fsum(input logic [4:0] x, en, input logic p, e);
		@(posedge clk_sys);
		fsc_write <= !p;
		fp_enabled_exc <= p;
		fsc_exc_bits <= x;
		fsc_en_bits <= en;
		@(posedge clk_sys);
		{fsc_write, fp_enabled_exc} <= 2'b00;
		@(negedge clk_sys);
		chk(float_enabled_summary === e, "summary flag");
	endtask

	task automatic chk_irq(input logic e);
		repeat (2) @(posedge clk_sys);
		@(negedge clk_sys);
		chk(irq === e, "irq level");
	endtask

	// ****************************************
	// output watcher
	// ****************************************
	always @(negedge clk_sys) begin
		if (saw_read) begin
			chk(rd_q.size() != 0 && reg_rdata === rd_q[0], "read data");
			if (rd_q.size() != 0) void'(rd_q.pop_front());
		end
		saw_read = reg_read;
		if (exc_take === 1'b1) begin
			chk(off_q.size() != 0, "unexpected take");
			if (off_q.size() != 0) begin
				chk(exc_kind_offset === off_q[0], "offset");
				chk(exc_fetch_addr === vb + {12'h000, off_q[0]}, "fetch");
				chk(saved_status_word === cause_q[0], "cause");
				void'(off_q.pop_front());
				void'(cause_q.pop_front());
			end
		end
	end

	initial begin
		#200us;
		chk(1'b0, "timeout");
		tally_and_finish();
	end

	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		repeat (5) @(posedge clk_sys);
		reset <= 1'b0;
		seed = xs(seed);
		down_counter_reg <= {1'b0, seed[30:0]};
		reg_rd(REG_MASK, MASK_RESET);
		reg_rd(REG_CONTROL, CONTROL_RESET);
		reg_rd(REG_STATUS, 32'h00000000);
		seed = xs(seed);
		vb = seed;
		reg_wr(REG_VBASE, vb);
		reg_rd(REG_VBASE, vb);
		note(VEC_SYS_CALL, 4'h0);
		issue(7'b1000000);
		note(VEC_FLOAT_UNAVAIL, 4'h0);
		issue(7'b0000001);
		note(VEC_PROGRAM, 4'h2);
		issue(7'b0000010);
		issue(7'b0000100);
		machine_state_word[MSW_PR_POS] <= 1'b1;
		note(VEC_PROGRAM, 4'h4);
		issue(7'b0000100);
		seed = xs(seed);
		special_register_number <= {1'b1, seed[8:0]};
		note(VEC_PROGRAM, 4'h4);
		issue(7'b0011000);
		note(VEC_PROGRAM, 4'h8);
		issue(7'b0100000);
		note(VEC_PROGRAM, 4'h2);
		issue(7'b1000010);
		fsum(5'h04, 5'h08, 1'b0, 1'b0);
		fsum(5'h00, 5'h00, 1'b1, 1'b1);
		fsum(5'h01, 5'h02, 1'b0, 1'b0);
		fsum(5'h10, 5'h10, 1'b0, 1'b1);
		machine_state_word[MSW_FP_POS] <= 1'b1;
		issue(7'b0000001);
		for (int i = 0; i < 2; i++) begin
			machine_state_word[MSW_FE0_POS] <= (i == 0);
			machine_state_word[MSW_FE1_POS] <= (i == 1);
			note(VEC_PROGRAM, 4'h1);
			issue(7'b0000001);
		end
		reg_wr(REG_CONTROL, 32'h00000001);
		note(VEC_FLOAT_UNAVAIL, 4'h0);
		issue(7'b0000001);
		reg_wr(REG_CONTROL, 32'h00000000);
		@(posedge clk_sys);
		down_counter_reg[DOWN_COUNTER_MSB] <= 1'b1;
		repeat (5) @(posedge clk_sys);
		note(VEC_DOWN_COUNTER, 4'h0);
		machine_state_word[MSW_EE_POS] <= 1'b1;
		repeat (5) @(posedge clk_sys);
		// back to back: the second instruction meets the gap cycle
		note(VEC_SYS_CALL, 4'h0);
		@(posedge clk_sys);
		instr_valid <= 1'b1;
		instr_is_sc <= 1'b1;
		@(posedge clk_sys);
		{instr_is_sc, instr_illegal} <= 2'b01;
		@(posedge clk_sys);
		{instr_valid, instr_illegal} <= 2'b00;
		repeat (3) @(posedge clk_sys);
		reg_rd(REG_STATUS, 32'h0000000F);
		reg_rd(REG_CAUSE, {28'h0, cause});
		reg_wr(REG_CAUSE, 32'h0000000F);
		reg_rd(REG_CAUSE, {28'h0, cause});
		reg_wr(REG_MASK, 32'h00000008);
		reg_rd(REG_MASK, 32'h00000008);
		chk_irq(1'b1);
		reg_wr(REG_STATUS, 32'h00000008);
		chk_irq(1'b0);
		reg_rd(REG_STATUS, 32'h00000007);
		reg_wr(REG_STATUS, 32'h00000007);
		reg_wr(4'hF, 32'hFFFFFFFF);
		reg_rd(4'hF, 32'h00000000);
		reg_rd(REG_STATUS, 32'h00000000);
		for (int i = 0; i < 20 && off_q.size() + rd_q.size() != 0; i++)
			@(posedge clk_sys);
		chk(off_q.size() + rd_q.size() == 0, "missing result");
		tally_and_finish();
	end
endmodule
`default_nettype wire
